// *** hw/keypad_edge_level_interrupt.sv ***
// keypad interrupt unit: registers, request latch, mask and wake
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_params.svh"

module keypad_edge_level_interrupt #(
	parameter int N = 8
) (
	// clock and reset
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst,
	// register port
	input  wire logic [`KP_ADDR_W-1:0]  i_addr,
	input  wire logic [7:0]             i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [7:0]             o_rdata,
	// cpu side
	input  wire logic                   i_vector_fetch,
	input  wire logic                   i_break_state,
	output logic                        o_irq,
	output logic                        o_wake,
	output logic      [15:0]            o_vector_addr,
	// port pins
	input  wire logic [N-1:0]           i_port_pin,
	input  wire logic [N-1:0]           i_port_direction_bits,
	output logic      [N-1:0]           o_port_data_valid,
	output logic      [N-1:0]           o_pull_up,
	output logic      [N-1:0]           o_pull_down,
	output logic      [N-1:0]           o_force_input
);
	typedef struct packed {
		logic         latch;
		logic         request;
		logic         mask;
		logic         sens;
		logic         break_clear_enable;
		logic [N-1:0] pin_interrupt_enable;
		logic [N-1:0] pin_polarity_select;
		logic [7:0]   rdata;
		logic         irq;
		logic         wake;
		logic [N-1:0] data_valid;
		logic [N-1:0] pull_up;
		logic [N-1:0] pull_down;
		logic [N-1:0] force_in;
	} kp_state_t;

	kp_state_t st_q;
	kp_state_t st_d;
	keypad_pkg::pin_ctrl_t pin_ctrl;
	logic [N-1:0] asserted;
	logic [N-1:0] edges;
	logic         any_asserted;
	logic         set_req;
	logic         level_hold;
	logic         ack;
	logic         sw_ack;
	logic         clr_req;

	// address match used by both read and write decode
	function automatic logic hit(input logic [`KP_ADDR_W-1:0] a, input logic [`KP_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	keypad_pin_detect #(.N(N)) u_detect (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_enable   (st_q.pin_interrupt_enable),
		.i_polarity (st_q.pin_polarity_select),
		.i_pins     (i_port_pin),
		.o_asserted (asserted),
		.o_edge     (edges)
	);

	keypad_pull_ctrl #(.N(N)) u_pull (
		.i_enable   (st_q.pin_interrupt_enable),
		.i_polarity (st_q.pin_polarity_select),
		.o_ctrl     (pin_ctrl)
	);

	// request set and clear conditions
	always_comb begin
		any_asserted = |asserted;
		// edge-only: one or more newly asserted pins and no other pin already asserted
		// the latch only ever takes edges; a held level is added beside it, not stored in it
		if (st_q.sens) begin
			set_req = |edges;
		end else begin
			set_req = (|edges) && ((asserted & ~edges) == '0);
		end
		// level mode: a held pin keeps the request present whatever the latch holds
		level_hold = st_q.sens && any_asserted;
		sw_ack = i_wr && hit(i_addr, `KP_OFF_STATUS_CTRL) && i_wdata[`KP_BIT_ACK];
		// break protects the latch unless break clear enable is set
		if (i_break_state && !st_q.break_clear_enable) begin
			ack = 1'b0;
		end else begin
			ack = sw_ack || i_vector_fetch;
		end
		clr_req = ack;
	end

	// next state: registers, latch and outputs
	always_comb begin
		st_d = st_q;
		// set wins over clear; an ack taken while a pin is held still empties the latch,
		// so in level mode the request drops on the ack or the release, whichever of the two events comes last
		if (set_req) begin
			st_d.latch = 1'b1;
		end else if (clr_req) begin
			st_d.latch = 1'b0;
		end
		st_d.request = st_d.latch || level_hold;
		if (i_wr) begin
			if (hit(i_addr, `KP_OFF_STATUS_CTRL)) begin
				st_d.mask = i_wdata[`KP_BIT_MASK];
				st_d.sens = i_wdata[`KP_BIT_SENS];
			end else if (hit(i_addr, `KP_OFF_PIN_ENABLE)) begin
				st_d.pin_interrupt_enable = i_wdata[N-1:0];
			end else if (hit(i_addr, `KP_OFF_PIN_POLAR)) begin
				st_d.pin_polarity_select = i_wdata[N-1:0];
			end else if (hit(i_addr, `KP_OFF_BREAK_CTRL)) begin
				st_d.break_clear_enable = i_wdata[`KP_BIT_BRK_CLR_EN];
			end
		end
		// read data stands only in the cycle after the strobe
		st_d.rdata = 8'h00;
		if (i_rd) begin
			if (hit(i_addr, `KP_OFF_STATUS_CTRL)) begin
				// upper nibble and acknowledge read zero
				st_d.rdata = {4'h0, st_q.request, 1'b0, st_q.mask, st_q.sens};
			end else if (hit(i_addr, `KP_OFF_PIN_ENABLE)) begin
				st_d.rdata = 8'(st_q.pin_interrupt_enable);
			end else if (hit(i_addr, `KP_OFF_PIN_POLAR)) begin
				st_d.rdata = 8'(st_q.pin_polarity_select);
			end else if (hit(i_addr, `KP_OFF_BREAK_CTRL)) begin
				st_d.rdata = {7'h00, st_q.break_clear_enable};
			end
		end
		// irq and wake change on the same edge as the latch, staying registered
		st_d.irq        = st_d.request && !st_d.mask;
		st_d.wake       = st_d.request && !st_d.mask;
		st_d.data_valid = ~i_port_direction_bits;
		st_d.pull_up    = pin_ctrl.pull_up;
		st_d.pull_down  = pin_ctrl.pull_down;
		st_d.force_in   = pin_ctrl.force_input;
	end

	// reset clears latch, mask, sensitivity and all pin settings
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_rdata           = st_q.rdata;
	assign o_irq             = st_q.irq;
	assign o_wake            = st_q.wake;
	assign o_vector_addr     = `KP_VECTOR_HI;
	assign o_port_data_valid = st_q.data_valid;
	assign o_pull_up         = st_q.pull_up;
	assign o_pull_down       = st_q.pull_down;
	assign o_force_input     = st_q.force_in;

	// checks
	chk_irq_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_irq == (st_q.request && !st_q.mask))
		else $error("irq does not follow request and mask");
	chk_mask_blocks: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		st_q.mask |-> !o_irq && !o_wake)
		else $error("masked request reached cpu");
	chk_edge_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		set_req |=> st_q.latch && st_q.request)
		else $error("edge did not set request");
	chk_edge_blocked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(!st_q.sens && !st_q.latch && (|(asserted & ~edges))) |=> !st_q.latch)
		else $error("edge set request while other pin asserted");
	// level mode: an ack taken with all pins released ends the request
	chk_level_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(st_q.sens && ack && !set_req && !any_asserted) |=> !st_q.request)
		else $error("level request stayed after ack and release");
	chk_fetch_ack: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_vector_fetch && !i_break_state && !set_req) |=> !st_q.latch)
		else $error("vector fetch did not acknowledge");
	chk_pending_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_rd && i_addr == `KP_OFF_STATUS_CTRL) |=> o_rdata[`KP_BIT_PENDING] == $past(st_q.request))
		else $error("pending flag does not show request");
	chk_wake_irq: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_wake == o_irq)
		else $error("wake differs from irq");
	chk_force_input: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_force_input == $past(st_q.pin_interrupt_enable))
		else $error("enabled pin not forced to input");
	chk_pull_polarity: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(o_pull_down & ~$past(st_q.pin_polarity_select)) == '0)
		else $error("pull-down on a low polarity pin");
	chk_disabled_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(asserted & ~st_q.pin_interrupt_enable) == '0)
		else $error("disabled pin reported asserted");
	chk_sens_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_wr && i_addr == `KP_OFF_STATUS_CTRL) |=> st_q.sens == $past(i_wdata[`KP_BIT_SENS]))
		else $error("sensitivity bit not written");
	chk_level_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(st_q.sens && any_asserted) |=> st_q.request)
		else $error("level request dropped while pin asserted");
	chk_ack_clears: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(!st_q.sens && sw_ack && !i_break_state && !set_req) |=> !st_q.request)
		else $error("acknowledge did not clear request");
	chk_break_protect: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_break_state && !st_q.break_clear_enable && st_q.latch) |=> st_q.latch)
		else $error("request cleared during protected break");
	chk_status_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$past(i_rd) |-> o_rdata[7:4] == 4'h0 && !(o_rdata[`KP_BIT_ACK] && $past(i_addr) == `KP_OFF_STATUS_CTRL))
		else $error("reserved or acknowledge bits read nonzero");
	chk_pull_select: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(o_pull_up & o_pull_down) == '0)
		else $error("pull-up and pull-down both on");
	cov_edge_irq: cover property (@(posedge i_ref_clk) disable iff (i_rst) !st_q.sens && set_req ##1 o_irq);
	cov_level_irq: cover property (@(posedge i_ref_clk) disable iff (i_rst) st_q.sens && set_req ##2 o_irq);
	cov_fetch_ack: cover property (@(posedge i_ref_clk) disable iff (i_rst) st_q.request && i_vector_fetch);
	cov_break_ack: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_break_state && sw_ack && st_q.break_clear_enable);
	cov_ack_held: cover property (@(posedge i_ref_clk) disable iff (i_rst) st_q.sens && ack && any_asserted);
endmodule : keypad_edge_level_interrupt
`default_nettype wire

// *** hw/keypad_params.svh ***
// register offsets, field positions and reset values of the keypad interrupt unit
`ifndef KEYPAD_PARAMS_SVH
`define KEYPAD_PARAMS_SVH

`define KP_ADDR_W          4
`define KP_OFF_STATUS_CTRL 4'h0
`define KP_OFF_PIN_ENABLE  4'h1
`define KP_OFF_PIN_POLAR   4'h2
`define KP_OFF_BREAK_CTRL  4'h3
`define KP_BIT_PENDING     3
`define KP_BIT_ACK         2
`define KP_BIT_MASK        1
`define KP_BIT_SENS        0
`define KP_BIT_BRK_CLR_EN  0
`define KP_RST_BYTE        8'h00
`define KP_VECTOR_HI       16'hFFE0
`define KP_VECTOR_LO       16'hFFE1

`endif

// *** hw/keypad_pkg.sv ***
// types shared by the keypad interrupt unit
package keypad_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [7:0] pull_up;
		logic [7:0] pull_down;
		logic [7:0] force_input;
	} pin_ctrl_t;

endpackage : keypad_pkg

// *** hw/keypad_pin_detect.sv ***
// per-pin edge and level detection for the keypad pins
`timescale 1ns/1ps
`default_nettype none
module keypad_pin_detect #(
	parameter int N = 8
) (
	// clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	// configuration
	input  wire logic [N-1:0] i_enable,
	input  wire logic [N-1:0] i_polarity,
	// pins and results
	input  wire logic [N-1:0] i_pins,
	output logic      [N-1:0] o_asserted,
	output logic      [N-1:0] o_edge
);
	typedef struct packed {
		logic [N-1:0] prev;
	} det_state_t;

	det_state_t st_q;
	det_state_t st_d;
	logic [N-1:0] lvl;

	// asserted level follows polarity; disabled pins never assert
	assign lvl        = ~(i_pins ^ i_polarity) & i_enable;
	assign o_asserted = lvl;
	// deasserted in one bus cycle, asserted in the next
	assign o_edge     = lvl & ~st_q.prev;

	always_comb begin
		st_d      = st_q;
		st_d.prev = lvl;
	end

	// enabling a pin already asserted counts as an edge, so init flow must acknowledge
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : keypad_pin_detect
`default_nettype wire

// *** hw/keypad_pull_ctrl.sv ***
// pull device and direction override control for enabled keypad pins
`timescale 1ns/1ps
`default_nettype none
module keypad_pull_ctrl #(
	parameter int N = 8
) (
	input  wire logic [N-1:0]        i_enable,
	input  wire logic [N-1:0]        i_polarity,
	output keypad_pkg::pin_ctrl_t    o_ctrl
);
	// pull-up for low polarity, pull-down for high; enable forces input
	always_comb begin
		o_ctrl             = '0;
		o_ctrl.pull_up     = i_enable & ~i_polarity;
		o_ctrl.pull_down   = i_enable & i_polarity;
		o_ctrl.force_input = i_enable;
	end
endmodule : keypad_pull_ctrl
`default_nettype wire

// *** test/keypad_switches.sv ***
// behavioural keypad switches and pull devices on the port pins
`timescale 1ns/1ps
`default_nettype none
module keypad_switches (
	// clock
	input  wire logic       i_ref_clk,
	// switch state and pull devices
	input  wire logic [7:0] i_press,
	input  wire logic [7:0] i_pull_up,
	input  wire logic [7:0] i_pull_down,
	// pins
	output logic      [7:0] o_pin
);
	logic tog_q = 1'b0;
	// an unpulled pin floats; a changing pattern keeps a stale level from passing
	always_ff @(posedge i_ref_clk) begin
		tog_q <= ~tog_q;
	end
	// a pressed switch pulls the pin to the rail opposite its pull device
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			o_pin[i] = i_pull_up[i] ? ~i_press[i] : (i_pull_down[i] ? i_press[i] : tog_q);
		end
	end
endmodule : keypad_switches
`default_nettype wire

// *** test/tb_top.sv ***
// register level test of the keypad interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "keypad_params.svh"
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, ac); end end
module tb_top;
	logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, vf = 1'b0, brk = 1'b0;
	logic [3:0]  i_addr = 4'h0;
	logic [7:0]  i_wdata = 8'h00, press = 8'h00, dir = 8'hFF;
	logic [7:0]  o_rdata, pins, dvalid, pu, pd, fin;
	logic        o_irq, o_wake;
	logic [15:0] vaddr;
	int          err_total = 0, compares = 0;
	localparam logic [3:0] SC = `KP_OFF_STATUS_CTRL;
	// free running bench clock
	always #4 i_ref_clk = ~i_ref_clk;
	keypad_edge_level_interrupt DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vector_fetch(vf),
		.i_break_state(brk), .o_irq(o_irq), .o_wake(o_wake), .o_vector_addr(vaddr),
		.i_port_pin(pins), .i_port_direction_bits(dir), .o_port_data_valid(dvalid),
		.o_pull_up(pu), .o_pull_down(pd), .o_force_input(fin));
	keypad_switches sw (.i_ref_clk(i_ref_clk), .i_press(press), .i_pull_up(pu), .i_pull_down(pd), .o_pin(pins));
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_ref_clk);
		i_rd <= 1'b1; i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 `CHK("rdata", e, o_rdata)
	endtask : rd
	// registered outputs lag the register write by one more edge
	task settle;
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask : settle
	task act(input logic [7:0] p);
		@(posedge i_ref_clk);
		press <= p;
		repeat (4) @(posedge i_ref_clk);
		#1;
	endtask : act
	task test_done;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	// a hang is cut short at 12500 cycles, well beyond the roughly 180 cycles the tests need
	initial begin
		#100000;
		err_total++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		#1 `CHK("vector", 16'hFFE0, vaddr)
		rd(SC, 8'h00);
		rd(`KP_OFF_PIN_ENABLE, 8'h00);
		rd(`KP_OFF_PIN_POLAR, 8'h00);
		dir <= 8'hF0;
		wr(SC, 8'h02);
		wr(`KP_OFF_PIN_ENABLE, 8'h0F);
		wr(`KP_OFF_PIN_POLAR, 8'h0C);
		settle;
		`CHK("pull_up", 8'h03, pu)
		`CHK("pull_down", 8'h0C, pd)
		`CHK("force_in", 8'h0F, fin)
		`CHK("dvalid", 8'h0F, dvalid)
		wr(SC, 8'h06);
		wr(SC, 8'h00);
		rd(SC, 8'h00);
		act(8'h01);
		`CHK("irq", 1'b1, o_irq)
		`CHK("wake", 1'b1, o_wake)
		rd(SC, 8'h08);
		act(8'h00);
		wr(SC, 8'h02);
		settle;
		`CHK("irq", 1'b0, o_irq)
		`CHK("wake", 1'b0, o_wake)
		rd(SC, 8'h0A);
		wr(SC, 8'h04);
		rd(SC, 8'h00);
		act(8'h04);
		`CHK("irq", 1'b1, o_irq)
		@(posedge i_ref_clk);
		vf <= 1'b1;
		@(posedge i_ref_clk);
		vf <= 1'b0;
		settle;
		`CHK("irq", 1'b0, o_irq)
		act(8'h00);
		rd(SC, 8'h00);
		act(8'h08);
		rd(SC, 8'h08);
		wr(SC, 8'h04);
		// pin1 held keeps the edge on pin0 from latching
		act(8'h02);
		wr(SC, 8'h04);
		act(8'h03);
		rd(SC, 8'h00);
		act(8'h00);
		wr(SC, 8'h01);
		act(8'h08);
		// ack while the pin is held: request stays, then ends on release alone
		wr(SC, 8'h05);
		rd(SC, 8'h09);
		act(8'h00);
		rd(SC, 8'h01);
		// release first, then ack
		act(8'h08);
		act(8'h00);
		rd(SC, 8'h09);
		wr(SC, 8'h05);
		rd(SC, 8'h01);
		wr(SC, 8'h00);
		act(8'h01);
		act(8'h00);
		@(posedge i_ref_clk);
		brk <= 1'b1;
		wr(SC, 8'h04);
		rd(SC, 8'h08);
		wr(`KP_OFF_BREAK_CTRL, 8'h01);
		wr(SC, 8'h04);
		@(posedge i_ref_clk);
		brk <= 1'b0;
		rd(SC, 8'h00);
		rd(4'h9, 8'h00);
		wr(SC, 8'hF2);
		rd(SC, 8'h02);
		wr(SC, 8'h01);
		act(8'h01);
		`CHK("irq", 1'b1, o_irq)
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		@(posedge i_ref_clk);
		i_rst <= 1'b0;
		#1 `CHK("irq", 1'b0, o_irq)
		rd(SC, 8'h00);
		test_done;
	end
endmodule : tb_top
`default_nettype wire
